// >>> hw/stack_table_params.svh
// constants for the stack, table write and indexed execution block
`ifndef STACK_TABLE_PARAMS_SVH
`define STACK_TABLE_PARAMS_SVH
`define OP_POP         16'h0006
`define OP_PUSH        16'h0005
`define OP_TBLWR_BASE  16'h000c
`define OP_ADD_HI6     6'h09
`define OP_BSET_HI4    4'h8
`define OP_INDEXED_SET_ONES_OP_HI8    8'h68
`define PC_STEP        21'h000002
`define PTR_STEP       21'h000001
`define K_MAX          8'h5f
`define ONES_BYTE      8'hff
`define TP_RESET       21'h000000
`define FSR_RESET      12'h000
`define MODE_NOCHG     2'h0
`define MODE_POSTINC   2'h1
`define MODE_POSTDEC   2'h2
`define MODE_PREINC    2'h3
`define FLAG_N         4
`define FLAG_OV        3
`define FLAG_Z         2
`define FLAG_DC        1
`define FLAG_C         0
`endif

// >>> hw/stack_table_pkg.sv
// types for the stack, table write and indexed execution block
package stack_table_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TWAIT = 3'b010,
    ST_TWRT  = 3'b100
  } exec_state_t;
  typedef logic [7:0]  byte_t;
  typedef logic [20:0] tptr_t;
endpackage

// >>> hw/hold_reg_bank.sv
// bank of holding registers loaded by table writes
`timescale 1ns/1ps
`include "stack_table_params.svh"
module hold_reg_bank #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // write side
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_idx,
  input  wire logic [7:0]        wr_data,
  // staged image
  output logic [DEPTH*8-1:0]     hold_image
);
  logic [7:0] hold_ff [DEPTH];
  logic [7:0] nxt_hold [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_hold[i] = hold_ff[i];
    end
    if (wr_en) begin
      nxt_hold[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        hold_ff[i] <= `ONES_BYTE;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        hold_ff[i] <= nxt_hold[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      hold_image[i*8 +: 8] = hold_ff[i];
    end
  end
endmodule // hold_reg_bank

// >>> hw/stack_table_exec.sv
// execution unit for stack, table write and indexed literal offset ops
// ============================================================
// Summary of operation
// RULE1: pop drops stack top; previous entry becomes top; one cycle, no flags.
// RULE2: push stores pc plus two on stack top; one cycle, no flags.
// RULE3: table write mode field: none, post-inc, post-dec, pre-inc.
// RULE4: pre-inc bumps pointer before write; post modes write then update.
// RULE5: low pointer bits pick one of eight holding registers.
// RULE6: table pointer is 21 bits, byte addressed, two megabytes.
// RULE7: pointer bit zero picks low or high byte of word.
// RULE8: holding registers only stage data; program memory untouched here.
// RULE9: indexed add sums accumulator and reg at base plus k, sets flags.
// RULE10: destination bit 0 writes accumulator, 1 writes register.
// RULE11: with extended set, 0010 01d0 plus literal decodes indexed add.
// RULE12: indexed set-ones writes ff at base plus k, no flags.
// RULE13: indexed bit-set sets bit b at base plus k, no flags.
`timescale 1ns/1ps
`include "stack_table_params.svh"
module stack_table_exec
  import stack_table_pkg::*;
#(
  parameter int DEPTH   = 31,
  parameter int SPW     = 5,
  parameter int HOLD_N  = 8,
  parameter int HOLD_AW = 3
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // instruction issue
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  input  wire logic               ext_set_en,
  input  wire logic [20:0]        pc_in,
  // data memory read port, same clock
  input  wire logic [7:0]         dmem_rdata,
  // table pointer, latch, fsr and accumulator loads from core
  input  wire logic               tp_load,
  input  wire logic [20:0]        tp_load_val,
  input  wire logic               tl_load,
  input  wire logic [7:0]         tl_load_val,
  input  wire logic               fsr_load,
  input  wire logic [11:0]        fsr_load_val,
  input  wire logic               acc_load,
  input  wire logic [7:0]         acc_load_val,
  // data memory write port and read address
  output logic                    dmem_we,
  output logic [11:0]             dmem_waddr,
  output logic [7:0]              dmem_wdata,
  output logic [11:0]             dmem_raddr,
  // architectural state
  output logic [20:0]             return_stack_top,
  output logic [SPW-1:0]          stack_depth,
  output logic [20:0]             table_pointer,
  output logic [7:0]              table_latch,
  output logic                    byte_hi_sel,
  output logic [7:0]              accum,
  output logic [4:0]              status_flags,
  output logic                    busy,
  output logic [HOLD_N*8-1:0]     hold_image
);
  // ==========================================================
  // decode
  logic        dec_pop;
  logic        dec_push;
  logic        dec_tblwr;
  logic        dec_add;
  logic        dec_bset;
  logic        dec_indexed_set_ones_op;
  logic [7:0]  lit_k;
  logic [11:0] idx_addr;

  assign lit_k    = instr_word[7:0];
  assign dec_pop  = instr_valid && instr_word == `OP_POP;   // see RULE1
  assign dec_push = instr_valid && instr_word == `OP_PUSH;  // see RULE2
  assign dec_tblwr = instr_valid && instr_word[15:2] == 14'(`OP_TBLWR_BASE >> 2); // see RULE3
  assign dec_add  = instr_valid && ext_set_en && instr_word[15:10] == `OP_ADD_HI6
                    && !instr_word[8] && lit_k <= `K_MAX;   // see RULE11
  assign dec_bset = instr_valid && ext_set_en && instr_word[15:12] == `OP_BSET_HI4
                    && !instr_word[8] && lit_k <= `K_MAX;   // see RULE13
  assign dec_indexed_set_ones_op = instr_valid && ext_set_en && instr_word[15:8] == `OP_INDEXED_SET_ONES_OP_HI8
                    && lit_k <= `K_MAX;                     // see RULE12
  // ==========================================================
  // return stack
  logic [20:0]    stk_ff [DEPTH];
  logic [20:0]    nxt_stk [DEPTH];
  logic [SPW-1:0] sp_ff;
  logic [SPW-1:0] nxt_sp;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_stk[i] = stk_ff[i];
    end
    nxt_sp = sp_ff;
    if (dec_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_stk[i] = stk_ff[i+1];                           // see RULE1
      end
      nxt_stk[DEPTH-1] = `TP_RESET;
      if (sp_ff != '0) begin
        nxt_sp = sp_ff - 1'b1;
      end
    end else if (dec_push) begin
      for (int i = 1; i < DEPTH; i++) begin
        nxt_stk[i] = stk_ff[i-1];                           // see RULE2
      end
      nxt_stk[0] = pc_in + `PC_STEP;                        // see RULE2
      if (sp_ff != SPW'(DEPTH)) begin
        nxt_sp = sp_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stk_ff[i] <= `TP_RESET;
      end
      sp_ff <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stk_ff[i] <= nxt_stk[i];
      end
      sp_ff <= nxt_sp;
    end
  end
  // ==========================================================
  // table write sequencer
  exec_state_t state_ff;
  exec_state_t nxt_state;
  tptr_t       tp_ff;
  tptr_t       nxt_tp;
  tptr_t       wr_ptr_ff;
  tptr_t       nxt_wr_ptr;
  byte_t       tl_ff;
  byte_t       nxt_tl;
  logic        hold_we;

  always_comb begin
    nxt_state  = state_ff;
    nxt_tp     = tp_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_tl     = tl_load ? tl_load_val : tl_ff;
    hold_we    = 1'b0;
    if (tp_load) begin
      nxt_tp = tp_load_val;                                 // see RULE6
    end
    case (state_ff)
      ST_IDLE: begin
        if (dec_tblwr) begin
          nxt_state = ST_TWAIT;
          case (instr_word[1:0])
            `MODE_NOCHG: begin
              nxt_wr_ptr = tp_ff;                           // see RULE3
            end
            `MODE_POSTINC: begin
              nxt_wr_ptr = tp_ff;                           // see RULE4
              nxt_tp     = tp_ff + `PTR_STEP;
            end
            `MODE_POSTDEC: begin
              nxt_wr_ptr = tp_ff;                           // see RULE4
              nxt_tp     = tp_ff - `PTR_STEP;
            end
            `MODE_PREINC: begin
              nxt_wr_ptr = tp_ff + `PTR_STEP;               // see RULE4
              nxt_tp     = tp_ff + `PTR_STEP;
            end
            default: begin
              nxt_wr_ptr = tp_ff;
            end
          endcase
        end
      end
      ST_TWAIT: begin
        nxt_state = ST_TWRT;
      end
      ST_TWRT: begin
        hold_we   = 1'b1;                                   // see RULE8
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff  <= ST_IDLE;
      tp_ff     <= `TP_RESET;
      wr_ptr_ff <= `TP_RESET;
      tl_ff     <= 8'h00;
    end else begin
      state_ff  <= nxt_state;
      tp_ff     <= nxt_tp;
      wr_ptr_ff <= nxt_wr_ptr;
      tl_ff     <= nxt_tl;
    end
  end

  hold_reg_bank #(
    .DEPTH (HOLD_N),
    .AW    (HOLD_AW)
  ) u_hold (
    .clock      (clock),
    .rst        (rst),
    .wr_en      (hold_we),
    .wr_idx     (wr_ptr_ff[HOLD_AW-1:0]),                   // see RULE5
    .wr_data    (tl_ff),
    .hold_image (hold_image)
  );
  // ==========================================================
  // indexed literal offset ops
  logic [11:0] fsr_ff;
  logic [11:0] nxt_fsr;
  byte_t       acc_ff;
  byte_t       nxt_acc;
  logic [4:0]  flg_ff;
  logic [4:0]  nxt_flg;
  logic        we_ff;
  logic        nxt_we;
  logic [11:0] wa_ff;
  logic [11:0] nxt_wa;
  byte_t       wd_ff;
  byte_t       nxt_wd;
  logic [8:0]  sum;
  logic [4:0]  nib;

  assign idx_addr = fsr_ff + {4'h0, lit_k};
  assign sum      = {1'b0, acc_ff} + {1'b0, dmem_rdata};
  assign nib      = {1'b0, acc_ff[3:0]} + {1'b0, dmem_rdata[3:0]};

  always_comb begin
    nxt_fsr = fsr_load ? fsr_load_val : fsr_ff;
    nxt_acc = acc_load ? acc_load_val : acc_ff;
    nxt_flg = flg_ff;
    nxt_we  = 1'b0;
    nxt_wa  = idx_addr;
    nxt_wd  = wd_ff;
    if (dec_add) begin
      nxt_flg[`FLAG_C]  = sum[8];                           // see RULE9
      nxt_flg[`FLAG_DC] = nib[4];
      nxt_flg[`FLAG_Z]  = sum[7:0] == 8'h00;
      nxt_flg[`FLAG_N]  = sum[7];
      nxt_flg[`FLAG_OV] = (acc_ff[7] == dmem_rdata[7]) && (sum[7] != acc_ff[7]);
      if (instr_word[9]) begin
        nxt_we = 1'b1;                                      // see RULE10
        nxt_wd = sum[7:0];
      end else begin
        nxt_acc = sum[7:0];                                 // see RULE10
      end
    end else if (dec_indexed_set_ones_op) begin
      nxt_we = 1'b1;
      nxt_wd = `ONES_BYTE;                                  // see RULE12
    end else if (dec_bset) begin
      nxt_we = 1'b1;
      nxt_wd = dmem_rdata | (8'h01 << instr_word[11:9]);    // see RULE13
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsr_ff <= `FSR_RESET;
      acc_ff <= 8'h00;
      flg_ff <= 5'h00;
      we_ff  <= 1'b0;
      wa_ff  <= `FSR_RESET;
      wd_ff  <= 8'h00;
    end else begin
      fsr_ff <= nxt_fsr;
      acc_ff <= nxt_acc;
      flg_ff <= nxt_flg;
      we_ff  <= nxt_we;
      wa_ff  <= nxt_wa;
      wd_ff  <= nxt_wd;
    end
  end
  // ==========================================================
  // outputs
  logic        busy_ff;
  logic        nxt_busy;

  always_comb begin
    nxt_busy = nxt_state != ST_IDLE;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  assign dmem_raddr       = idx_addr;
  assign dmem_we          = we_ff;
  assign dmem_waddr       = wa_ff;
  assign dmem_wdata       = wd_ff;
  assign return_stack_top = stk_ff[0];
  assign stack_depth      = sp_ff;
  assign table_pointer    = tp_ff;
  assign table_latch      = tl_ff;
  assign byte_hi_sel      = wr_ptr_ff[0];                   // see RULE7
  assign accum            = acc_ff;
  assign status_flags     = flg_ff;
  assign busy             = busy_ff;
endmodule // stack_table_exec

// >>> tb/stack_table_checker.sv
// assertion checker for the stack, table write and indexed block
`timescale 1ns/1ps
`include "stack_table_params.svh"
module stack_table_checker #(
  parameter int SPW = 5
) (
  // clock and reset
  input wire logic           clock,
  input wire logic           rst,
  // instruction issue and loads
  input wire logic           instr_valid,
  input wire logic [15:0]    instr_word,
  input wire logic           ext_set_en,
  input wire logic [20:0]    pc_in,
  input wire logic [7:0]     dmem_rdata,
  input wire logic           tp_load,
  input wire logic           acc_load,
  // observed state
  input wire logic           dmem_we,
  input wire logic [11:0]    dmem_waddr,
  input wire logic [7:0]     dmem_wdata,
  input wire logic [11:0]    dmem_raddr,
  input wire logic [20:0]    return_stack_top,
  input wire logic [SPW-1:0] stack_depth,
  input wire logic [20:0]    table_pointer,
  input wire logic [7:0]     accum,
  input wire logic [4:0]     status_flags,
  input wire logic           busy
);
  // ==========
  // helpers
  logic       tw;
  logic       ind;
  logic [2:0] bidx;
  assign tw   = instr_valid && instr_word[15:2] == 14'h3 && !busy && !tp_load;
  assign ind  = instr_valid && ext_set_en && instr_word[7:0] <= `K_MAX;
  assign bidx = instr_word[11:9];
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_pop;
    instr_valid && instr_word == `OP_POP && stack_depth > 1 |=> stack_depth == $past(stack_depth) - 1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop depth");
  property p_push;
    instr_valid && instr_word == `OP_PUSH |=> return_stack_top == $past(pc_in) + `PC_STEP;
  endproperty
  a_push: assert property (p_push) else $error("push top");
  property p_flag;
    instr_valid && instr_word[15:4] == 12'h0 |=> $stable(status_flags);
  endproperty
  a_flag: assert property (p_flag) else $error("flags moved");
  property p_busy;
    tw |=> busy [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_ptr;
    tw && instr_word[0] |=> table_pointer == $past(table_pointer) + `PTR_STEP;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step");
  property p_indexed_set_ones_op;
    ind && instr_word[15:8] == `OP_INDEXED_SET_ONES_OP_HI8 |=> dmem_we && dmem_wdata == `ONES_BYTE
      && dmem_waddr == $past(dmem_raddr);
  endproperty
  a_indexed_set_ones_op: assert property (p_indexed_set_ones_op) else $error("set ones");
  property p_bset;
    ind && instr_word[15:12] == `OP_BSET_HI4 && !instr_word[8] |=> dmem_we
      && dmem_wdata == ($past(dmem_rdata) | 8'h01 << $past(bidx));
  endproperty
  a_bset: assert property (p_bset) else $error("bit set");
  property p_add;
    ind && instr_word[15:8] == {`OP_ADD_HI6, 2'b00} && !acc_load |=> !dmem_we
      && accum == $past(accum) + $past(dmem_rdata);
  endproperty
  a_add: assert property (p_add) else $error("add to accum");
  property p_off;
    instr_valid && !ext_set_en |=> !dmem_we;
  endproperty
  a_off: assert property (p_off) else $error("write without ext");
endmodule // stack_table_checker
bind stack_table_exec stack_table_checker #(.SPW(SPW)) u_chk (.clock(clock), .rst(rst),
  .instr_valid(instr_valid), .ext_set_en(ext_set_en), .tp_load(tp_load), .acc_load(acc_load),
  .instr_word(instr_word), .pc_in(pc_in), .return_stack_top(return_stack_top),
  .table_pointer(table_pointer), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata),
  .accum(accum), .dmem_we(dmem_we), .busy(busy), .dmem_waddr(dmem_waddr),
  .dmem_raddr(dmem_raddr), .stack_depth(stack_depth), .status_flags(status_flags));

// >>> tb/testbench.sv
// self-checking testbench for the stack, table write and indexed block
`timescale 1ns/1ps
`include "stack_table_params.svh"
module testbench import stack_table_pkg::*;;
  logic        clock, rst, instr_valid, ext_set_en, tp_load, tl_load, fsr_load, acc_load;
  logic        dmem_we, byte_hi_sel, busy;
  logic [15:0] instr_word;
  tptr_t       pc_in, tp_load_val, return_stack_top, table_pointer;
  byte_t       dmem_rdata, tl_load_val, acc_load_val, dmem_wdata, table_latch, accum;
  logic [11:0] fsr_load_val, dmem_waddr, dmem_raddr;
  logic [4:0]  stack_depth, status_flags;
  logic [63:0] hold_image;
  byte_t       mem [4096];
  logic [19:0] expq [$];
  int          num_errors, checks;
  assign dmem_rdata = mem[dmem_raddr];
  stack_table_exec dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_set_en(ext_set_en), .pc_in(pc_in), .dmem_rdata(dmem_rdata),
    .tp_load(tp_load), .tp_load_val(tp_load_val), .tl_load(tl_load), .tl_load_val(tl_load_val),
    .fsr_load(fsr_load), .fsr_load_val(fsr_load_val), .acc_load(acc_load),
    .acc_load_val(acc_load_val), .dmem_we(dmem_we), .dmem_waddr(dmem_waddr),
    .dmem_wdata(dmem_wdata), .dmem_raddr(dmem_raddr), .return_stack_top(return_stack_top),
    .stack_depth(stack_depth), .table_pointer(table_pointer), .table_latch(table_latch),
    .byte_hi_sel(byte_hi_sel), .accum(accum), .status_flags(status_flags), .busy(busy),
    .hold_image(hold_image));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========
  // tasks
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    checks++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(logic [15:0] w, tptr_t p);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word  <= w;
    pc_in       <= p;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clock) instr_valid <= 1'b0;
    @(negedge clock);
  endtask
  task automatic ld(tptr_t tp, byte_t tl, logic [11:0] fs, byte_t ac);
    @(posedge clock);
    {tp_load, tl_load, fsr_load, acc_load} <= 4'hf;
    {tp_load_val, tl_load_val, fsr_load_val, acc_load_val} <= {tp, tl, fs, ac};
    @(posedge clock);
    {tp_load, tl_load, fsr_load, acc_load} <= 4'h0;
  endtask
  task automatic wait_idle();
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n == 8) begin
        num_errors++;
        give_verdict();
      end
      @(negedge clock);
    end
  endtask
  // data memory writes against noted results
  always @(posedge clock) begin
    if (dmem_we === 1'b1) begin
      chk("write", expq.size() ? expq.pop_front() : 'x, {dmem_waddr, dmem_wdata});
      mem[dmem_waddr] <= dmem_wdata;
    end
  end
  initial begin
    tptr_t       tp, ep, wp;
    tptr_t       pcs [3];
    byte_t       a, m, tl;
    logic [11:0] fs, ad;
    logic [8:0]  sm;
    logic [4:0]  fl;
    int          k, b;
    void'($urandom(32'ha07ba616));
    {rst, instr_valid, ext_set_en, tp_load, tl_load, fsr_load, acc_load} = 7'h40;
    instr_word = 16'h0;
    {pc_in, tp_load_val, tl_load_val, fsr_load_val, acc_load_val} = '0;
    foreach (mem[i]) mem[i] = byte_t'($urandom);
    num_errors = 0;
    checks = 0;
    fl = 5'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("hold", {8{8'hff}}, hold_image);
    for (int i = 0; i < 3; i++) begin
      pcs[i] = tptr_t'($urandom);
      op(`OP_PUSH, pcs[i]);
    end
    idle(1);
    ep = pcs[2] + `PC_STEP;
    chk("top", ep, return_stack_top);
    chk("depth", 3, stack_depth);
    op(`OP_POP, 0);
    op(`OP_POP, 0);
    idle(1);
    ep = pcs[0] + `PC_STEP;
    chk("top", ep, return_stack_top);
    chk("depth", 1, stack_depth);
    op(`OP_POP, 0);
    op(`OP_POP, 0);
    idle(1);
    chk("depth", 0, stack_depth);
    for (int md = 0; md < 4; md++) begin
      tp = tptr_t'($urandom);
      tl = byte_t'($urandom);
      ld(tp, tl, 12'h0, 8'h0);
      op(`OP_TBLWR_BASE | 16'(md), 0);
      if (md == 1) op(`OP_TBLWR_BASE | 16'(md), 0);
      idle(1);
      wait_idle();
      ep = (md == 2) ? tp - 1 : (md == 0) ? tp : tp + 1;
      wp = (md == 3) ? ep : tp;
      chk("pointer", ep, table_pointer);
      chk("byte_sel", wp[0], byte_hi_sel);
      chk("hold", tl, hold_image[wp[2:0]*8 +: 8]);
      chk("latch", tl, table_latch);
    end
    fs = 12'($urandom);
    a  = byte_t'($urandom);
    ld(21'h0, 8'h0, fs, a);
    @(posedge clock) ext_set_en <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      k  = (i == 0) ? 95 : $urandom_range(95);
      b  = $urandom_range(7);
      ad = fs + 12'(k);
      m  = mem[ad];
      sm = a + m;
      case (i % 4)
        0: op({`OP_INDEXED_SET_ONES_OP_HI8, 8'(k)}, 0);
        1: op({`OP_BSET_HI4, 3'(b), 1'b0, 8'(k)}, 0);
        default: op({`OP_ADD_HI6, i[0], 1'b0, 8'(k)}, 0);
      endcase
      if (i % 4 == 0) expq.push_back({ad, `ONES_BYTE});
      if (i % 4 == 1) expq.push_back({ad, m | byte_t'(1 << b)});
      if (i % 4 == 3) expq.push_back({ad, sm[7:0]});
      if (i % 4 > 1) fl = {sm[7], a[7] == m[7] && sm[7] != a[7], sm[7:0] == 0,
                           a[3:0] + m[3:0] > 15, sm[8]};
      idle(2);
      chk("flags", fl, status_flags);
      if (i % 4 == 2) a = sm[7:0];
      chk("accum", a, accum);
    end
    op({`OP_INDEXED_SET_ONES_OP_HI8, 8'h60}, 0);
    @(posedge clock) ext_set_en <= 1'b0;
    op({`OP_INDEXED_SET_ONES_OP_HI8, 8'h10}, 0);
    idle(3);
    chk("pending", 0, expq.size());
    give_verdict();
  end
endmodule // testbench
